// File: rtl/bbas_top.sv
/*
 * bbas_top: billboard attach sequencer for the internal function device.
 * assumes: the function device core reports address-set and alternate-mode
 * string requests as one-cycle pulses, and obeys o_connect and o_billboard (connect plus
 * descriptor set). descriptor contents live elsewhere.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - failure input low requests billboard function
// - failure input chosen by control bits 5:1
// - control bit 0 enables billboard support
// - low pin first forces function detach
// - reconnect presenting billboard class descriptors
// - timer A starts on address assignment
// - configured-state field reports unspecified error
// - string request starts timer B
// - either timer expiry forces detach
// - then reconnect with standard descriptors
// - timer A limit: 16 bits, 10 ms steps
// - timer A resets to 07d0h, 20 s
// - timer B limit at 413eh/413fh
module bbas_top #(
    parameter int TICK_CYCLES   = bbas_pkg::bbas_tick_cycles,
    parameter int DETACH_CYCLES = bbas_pkg::bbas_detach_cycles
) (
    input  wire logic                                i_clock,
    input  wire logic                                i_rst,
    input  wire logic [bbas_pkg::bbas_pin_count-1:0] i_general_pin,
    input  wire logic                                i_addr_set,
    input  wire logic                                i_alt_string_req,
    input  wire logic [15:0]                         i_reg_addr,
    input  wire logic [7:0]                          i_reg_wdata,
    input  wire logic                                i_reg_wr,
    input  wire logic                                i_reg_rd,
    output logic [7:0]                               o_reg_rdata,
    output logic                                     o_connect,
    output logic                                     o_billboard,
    output logic [1:0]                               o_configured
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            control;
        logic [15:0]           limit_a;
        logic [15:0]           limit_b;
        logic [1:0]            configured;
        bbas_pkg::bbas_state_e fsm;
        logic [17:0]           wait_count;
        logic [7:0]            rdata;
        bbas_pkg::bbas_attach_s attach;
    } bbas_top_s;

    bbas_top_s st;
    bbas_top_s next_st;
    bbas_pkg::bbas_bus_s bus;

    logic step;
    logic a_expired;
    logic b_expired;
    logic a_running;
    logic b_running;
    logic stop_timers;
    logic fail_req;
    logic sel_pin;

    assign bus = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

    // ------------------------------------------------------------
    // pin select
    // ------------------------------------------------------------
    // maps the 5-bit code to a pin; reserved and out-of-range codes read high
    function automatic logic pick_pin(input logic [4:0] code,
                                      input logic [bbas_pkg::bbas_pin_count-1:0] pins);
        if (code == bbas_pkg::bbas_sel_reserved ||
            code >= 5'(bbas_pkg::bbas_pin_count)) begin
            return 1'b1;
        end
        return pins[code];
    endfunction

    assign sel_pin  = pick_pin(st.control[bbas_pkg::bbas_ctl_sel_msb:bbas_pkg::bbas_ctl_sel_lsb],
                               i_general_pin);
    assign fail_req = st.control[bbas_pkg::bbas_ctl_enable_bit] && !sel_pin;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    bbas_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .o_tick  (step)
    );

    assign stop_timers = (st.fsm != bbas_pkg::bbas_st_billboard);

    bbas_timer u_timer_a (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_start   (i_addr_set && st.fsm == bbas_pkg::bbas_st_billboard),
        .i_stop    (stop_timers),
        .i_step    (step),
        .i_limit   (st.limit_a),
        .o_expired (a_expired),
        .o_running (a_running)
    );

    bbas_timer u_timer_b (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_start   (i_alt_string_req && st.fsm == bbas_pkg::bbas_st_billboard),
        .i_stop    (stop_timers),
        .i_step    (step),
        .i_limit   (st.limit_b),
        .o_expired (b_expired),
        .o_running (b_running)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;

        if (bus.wr) begin
            case (bus.addr)
                bbas_pkg::bbas_off_control: begin
                    // bits 7:6 always read zero
                    next_st.control = bus.wdata & bbas_pkg::bbas_ctl_write_mask;
                end
                bbas_pkg::bbas_off_timer_a_lo: next_st.limit_a[7:0]  = bus.wdata;
                bbas_pkg::bbas_off_timer_a_hi: next_st.limit_a[15:8] = bus.wdata;
                bbas_pkg::bbas_off_timer_b_lo: next_st.limit_b[7:0]  = bus.wdata;
                bbas_pkg::bbas_off_timer_b_hi: next_st.limit_b[15:8] = bus.wdata;
                bbas_pkg::bbas_off_configured: next_st.configured = bus.wdata[1:0];
                default: begin
                end
            endcase
        end

        if (bus.rd) begin
            case (bus.addr)
                bbas_pkg::bbas_off_control:    next_st.rdata = st.control;
                bbas_pkg::bbas_off_timer_a_lo: next_st.rdata = st.limit_a[7:0];
                bbas_pkg::bbas_off_timer_a_hi: next_st.rdata = st.limit_a[15:8];
                bbas_pkg::bbas_off_timer_b_lo: next_st.rdata = st.limit_b[7:0];
                bbas_pkg::bbas_off_timer_b_hi: next_st.rdata = st.limit_b[15:8];
                bbas_pkg::bbas_off_configured: next_st.rdata = {6'h00, st.configured};
                bbas_pkg::bbas_off_status: begin
                    next_st.rdata = {1'b0, st.fsm, b_running, a_running};
                end
                default: next_st.rdata = 8'h00;
            endcase
        end

        case (st.fsm)
            bbas_pkg::bbas_st_normal: begin
                next_st.attach = '{connect: 1'b1, billboard: 1'b0};
                if (fail_req) begin
                    next_st.fsm        = bbas_pkg::bbas_st_det_to_bb;
                    next_st.wait_count = 18'h0;
                    next_st.attach     = '{connect: 1'b0, billboard: 1'b0};
                end
            end
            bbas_pkg::bbas_st_det_to_bb: begin
                // hold the disconnect long enough for the host to see a detach
                if (st.wait_count == 18'(DETACH_CYCLES - 1)) begin
                    next_st.fsm    = bbas_pkg::bbas_st_billboard;
                    next_st.attach = '{connect: 1'b1, billboard: 1'b1};
                end else begin
                    next_st.wait_count = st.wait_count + 18'h1;
                end
            end
            bbas_pkg::bbas_st_billboard: begin
                if (a_expired || b_expired || !st.control[bbas_pkg::bbas_ctl_enable_bit]) begin
                    next_st.fsm        = bbas_pkg::bbas_st_det_to_std;
                    next_st.wait_count = 18'h0;
                    // billboard set kept until reconnect, so descriptors only swap on attach
                    next_st.attach     = '{connect: 1'b0, billboard: 1'b1};
                end
            end
            bbas_pkg::bbas_st_det_to_std: begin
                if (st.wait_count == 18'(DETACH_CYCLES - 1)) begin
                    next_st.fsm    = bbas_pkg::bbas_st_hold;
                    next_st.attach = '{connect: 1'b1, billboard: 1'b0};
                end else begin
                    next_st.wait_count = st.wait_count + 18'h1;
                end
            end
            bbas_pkg::bbas_st_hold: begin
                // no new billboard showing until fail_req drops: selected pin high, control bit 0 clear or another pin selected
                next_st.attach = '{connect: 1'b1, billboard: 1'b0};
                if (!fail_req) begin
                    next_st.fsm = bbas_pkg::bbas_st_normal;
                end
            end
            default: begin
                next_st.fsm    = bbas_pkg::bbas_st_normal;
                next_st.attach = '{connect: 1'b1, billboard: 1'b0};
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st.control    <= bbas_pkg::bbas_rst_control;
            st.limit_a    <= {bbas_pkg::bbas_rst_timer_hi, bbas_pkg::bbas_rst_timer_lo};
            st.limit_b    <= {bbas_pkg::bbas_rst_timer_hi, bbas_pkg::bbas_rst_timer_lo};
            st.configured <= bbas_pkg::bbas_rst_configured;
            st.fsm        <= bbas_pkg::bbas_st_normal;
            st.wait_count <= 18'h0;
            st.rdata      <= 8'h00;
            st.attach     <= '{connect: 1'b1, billboard: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_reg_rdata  = st.rdata;
    assign o_connect    = st.attach.connect;
    assign o_billboard  = st.attach.billboard;
    assign o_configured = st.configured;
endmodule

// File: rtl/bbas_pkg.sv
/*
 * bbas_pkg: constants and carrier types shared by the billboard attach sequencer.
 * assumes one 125 MHz clock and a plain register port with one-cycle strobes.
 */
package bbas_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] bbas_off_control     = 16'h0004;
    localparam logic [15:0] bbas_off_timer_a_lo  = 16'h413c;
    localparam logic [15:0] bbas_off_timer_a_hi  = 16'h413d;
    localparam logic [15:0] bbas_off_timer_b_lo  = 16'h413e;
    localparam logic [15:0] bbas_off_timer_b_hi  = 16'h413f;
    localparam logic [15:0] bbas_off_status      = 16'h4140;
    localparam logic [15:0] bbas_off_configured  = 16'h4142;

    localparam logic [7:0]  bbas_rst_control     = 8'h14;
    localparam logic [7:0]  bbas_rst_timer_lo    = 8'hd0;
    localparam logic [7:0]  bbas_rst_timer_hi    = 8'h07;
    localparam logic [1:0]  bbas_rst_configured  = 2'h0;

    // control byte fields
    localparam int          bbas_ctl_enable_bit  = 0;
    localparam int          bbas_ctl_sel_lsb     = 1;
    localparam int          bbas_ctl_sel_msb     = 5;
    localparam logic [7:0]  bbas_ctl_write_mask  = 8'h3f;
    localparam logic [4:0]  bbas_sel_reserved    = 5'h09;
    localparam int          bbas_pin_count       = 17;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          bbas_clock_mhz       = 125;
    localparam int          bbas_tick_ms         = 10;
    localparam int          bbas_tick_cycles     = bbas_tick_ms * 1000 * bbas_clock_mhz;
    localparam int          bbas_detach_ms       = 1;
    localparam int          bbas_detach_cycles   = bbas_detach_ms * 1000 * bbas_clock_mhz;

    typedef enum logic [4:0] {
        bbas_st_normal     = 5'b00001,
        bbas_st_det_to_bb  = 5'b00010,
        bbas_st_billboard  = 5'b00100,
        bbas_st_det_to_std = 5'b01000,
        bbas_st_hold       = 5'b10000
    } bbas_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bbas_bus_s;

    typedef struct packed {
        logic connect;
        logic billboard;
    } bbas_attach_s;

endpackage

// File: rtl/bbas_tick.sv
/*
 * bbas_tick: divider giving a one-cycle pulse every 10 ms step.
 * assumes the 125 MHz system clock; count shortened by parameter in simulation.
 */
`timescale 1ns/1ps
module bbas_tick #(
    parameter int TICK_CYCLES = bbas_pkg::bbas_tick_cycles
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    output logic      o_tick
);
    typedef struct packed {
        logic [20:0] count;
        logic        tick;
    } bbas_tick_s;

    bbas_tick_s st;
    bbas_tick_s next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.count == 21'(TICK_CYCLES - 1)) begin
            next_st.count = 21'h0;
            next_st.tick  = 1'b1;
        end else begin
            next_st.count = st.count + 21'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule

// File: rtl/bbas_timer.sv
/*
 * bbas_timer: one detach timer counting 10 ms steps up to a 16-bit limit.
 * assumes start and step are one-cycle pulses in the system clock; stop is a level.
 */
`timescale 1ns/1ps
module bbas_timer (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic        i_stop,
    input  wire logic        i_step,
    input  wire logic [15:0] i_limit,
    output logic             o_expired,
    output logic             o_running
);
    typedef struct packed {
        logic [15:0] count;
        logic        running;
        logic        expired;
    } bbas_timer_s;

    bbas_timer_s st;
    bbas_timer_s next_st;

    always_comb begin
        next_st         = st;
        next_st.expired = 1'b0;
        if (i_stop) begin
            next_st.running = 1'b0;
            next_st.count   = 16'h0;
        end else if (i_start && !st.running) begin
            next_st.running = 1'b1;
            next_st.count   = 16'h0;
        end else if (st.running && i_step) begin
            // a limit of zero expires at the first step
            if (st.count + 16'h1 >= i_limit) begin
                next_st.running = 1'b0;
                next_st.expired = 1'b1;
            end else begin
                next_st.count = st.count + 16'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_expired = st.expired;
    assign o_running = st.running;
endmodule

// File: sim/bbas_far_model.sv
/*
 * bbas_far_model: stand-in for the power delivery controller and the host.
 * assumes bench commands change right after a rising clock edge.
 */
`timescale 1ns/1ps
module bbas_far_model (
    input  wire logic                                i_fail,
    input  wire logic [4:0]                          i_sel,
    input  wire logic                                i_addr_cmd,
    input  wire logic                                i_str_cmd,
    output logic [bbas_pkg::bbas_pin_count-1:0]      o_pins,
    output logic                                     o_addr_set,
    output logic                                     o_alt_string_req
);
    // ------------------------------------------------------------
    // pins and host requests
    // ------------------------------------------------------------
    // idle pins sit high; a failure pulls only the chosen pin low
    always_comb begin
        o_pins = '1;
        if (i_fail && int'(i_sel) < bbas_pkg::bbas_pin_count) o_pins[i_sel] = 1'b0;
    end
    assign o_addr_set       = i_addr_cmd;
    assign o_alt_string_req = i_str_cmd;
endmodule

// File: sim/bbas_top_monitor.sv
/*
 * bbas_top_monitor: port assertions for the billboard attach sequencer.
 * assumes a bind into bbas_top; shadows control and configured bytes.
 */
`timescale 1ns/1ps
module bbas_top_monitor #(
    parameter int TICK_CYCLES   = 10,
    parameter int DETACH_CYCLES = 4
) (
    input wire logic                                i_clock,
    input wire logic                                i_rst,
    input wire logic [bbas_pkg::bbas_pin_count-1:0] i_general_pin,
    input wire logic [15:0]                         i_reg_addr,
    input wire logic [7:0]                          i_reg_wdata,
    input wire logic                                i_reg_wr,
    input wire logic                                i_reg_rd,
    input wire logic [7:0]                          o_reg_rdata,
    input wire logic                                o_connect,
    input wire logic                                o_billboard,
    input wire logic [1:0]                          o_configured
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [7:0]  ctl;
    logic [1:0]  cfg;
    logic [31:0] low_cnt;
    logic        sel_low;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctl     <= bbas_pkg::bbas_rst_control;
            cfg     <= bbas_pkg::bbas_rst_configured;
            low_cnt <= 32'h0;
        end else begin
            if (i_reg_wr && i_reg_addr == bbas_pkg::bbas_off_control)
                ctl <= i_reg_wdata & bbas_pkg::bbas_ctl_write_mask;
            if (i_reg_wr && i_reg_addr == bbas_pkg::bbas_off_configured)
                cfg <= i_reg_wdata[1:0];
            low_cnt <= o_connect ? 32'h0 : low_cnt + 32'h1;
        end
    end
    // reserved code behaves as an idle high pin
    always_comb begin
        sel_low = 1'b0;
        if (ctl[5:1] != bbas_pkg::bbas_sel_reserved && int'(ctl[5:1]) < bbas_pkg::bbas_pin_count)
            sel_low = !i_general_pin[ctl[5:1]];
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_reset_attach: assert property (@(posedge i_clock) disable iff (1'b0)
        i_rst |=> o_connect && !o_billboard && o_configured == 2'h0) else $error("reset state");
    a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data not idle");
    a_ctl_readback: assert property (i_reg_rd && i_reg_addr == bbas_pkg::bbas_off_control
        |=> o_reg_rdata == ctl) else $error("control readback");
    a_cfg_field: assert property (o_configured == cfg) else $error("configured field");
    a_bb_on_reconnect: assert property ($changed(o_billboard) |-> $rose(o_connect))
        else $error("descriptor set changed while attached");
    a_detach_span: assert property ($rose(o_connect) |-> low_cnt == DETACH_CYCLES)
        else $error("detach length");
    a_detach_cause: assert property ($fell(o_connect) && !o_billboard
        |-> $past(sel_low) && $past(ctl[0])) else $error("detach without low pin");
    a_disabled_idle: assert property (!ctl[0] && o_connect && !o_billboard
        |=> o_connect && !o_billboard) else $error("left standard while disabled");
    c_bb_entry: cover property ($rose(o_billboard));
    c_bb_exit: cover property ($fell(o_billboard));
    c_ctl_read: cover property (i_reg_rd && i_reg_addr == bbas_pkg::bbas_off_control);
endmodule

// File: sim/billboard_attach_sequencer_tb_top.sv
/*
 * billboard_attach_sequencer_tb_top: directed bench for bbas_top.
 * assumes short tick and detach counts; far side is bbas_far_model.
 */
`timescale 1ns/1ps
module billboard_attach_sequencer_tb_top;
    localparam int TICK = 10;
    localparam int DET  = 4;
    logic        i_clock, i_rst, reg_wr, reg_rd, fail, addr_cmd, str_cmd, connect, billboard;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, rdata;
    logic [4:0]  sel;
    logic [1:0]  configured;
    logic [bbas_pkg::bbas_pin_count-1:0] pins;
    logic        addr_set, alt_req;
    int          num_errors, checks, n;

    bbas_far_model far (.i_fail(fail), .i_sel(sel), .i_addr_cmd(addr_cmd), .i_str_cmd(str_cmd),
        .o_pins(pins), .o_addr_set(addr_set), .o_alt_string_req(alt_req));
    bbas_top #(.TICK_CYCLES(TICK), .DETACH_CYCLES(DET)) DUT (.i_clock(i_clock), .i_rst(i_rst),
        .i_general_pin(pins), .i_addr_set(addr_set), .i_alt_string_req(alt_req),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata), .o_connect(connect), .o_billboard(billboard),
        .o_configured(configured));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_span(input string name, input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge i_clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge i_clock);
        reg_rd <= 1'b0;
        #1;
        cmp8(name, exp, rdata);
    endtask
    // bounded wait; caller judges the count
    task automatic wait_conn(input logic want, input int max);
        n = 0;
        while (connect !== want && n < max) begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask
    task automatic enter_bb(input logic [4:0] code);
        sel <= code;
        wr(bbas_pkg::bbas_off_control, {2'b00, code, 1'b1});
        @(posedge i_clock);
        fail <= 1'b1;
        #1;
        wait_conn(1'b0, 6);
        cmp_span("detach_latency", n, 1, 3);
        wait_conn(1'b1, DET + 6);
        cmp_span("detach_length", n, DET - 1, DET + 1);
        cmp8("billboard_on", 8'h01, {7'h0, billboard});
    endtask
    task automatic pulse(input logic is_addr, input int lo, input int hi);
        @(posedge i_clock);
        if (is_addr) addr_cmd <= 1'b1;
        else str_cmd <= 1'b1;
        @(posedge i_clock);
        addr_cmd <= 1'b0;
        str_cmd  <= 1'b0;
        #1;
        wait_conn(1'b0, hi + 10);
        cmp_span("expiry", n, lo, hi);
        wait_conn(1'b1, DET + 6);
        cmp8("standard_back", 8'h00, {7'h0, billboard});
        // pin still low: must not rearm until it goes high
        repeat (10) @(posedge i_clock);
        #1;
        cmp8("hold_standard", 8'h02, {6'h0, connect, billboard});
        @(posedge i_clock);
        fail <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(bbas_pkg::bbas_off_control, 8'h14, "control");
        rd(bbas_pkg::bbas_off_timer_a_lo, 8'hd0, "timer_a_lo");
        rd(bbas_pkg::bbas_off_timer_a_hi, 8'h07, "timer_a_hi");
        rd(bbas_pkg::bbas_off_timer_b_lo, 8'hd0, "timer_b_lo");
        rd(bbas_pkg::bbas_off_timer_b_hi, 8'h07, "timer_b_hi");
        rd(bbas_pkg::bbas_off_configured, 8'h00, "configured");
        wr(16'h1234, 8'h5a);
        rd(16'h1234, 8'h00, "unmapped");
        wr(bbas_pkg::bbas_off_control, 8'hff);
        rd(bbas_pkg::bbas_off_control, 8'h3f, "control_mask");
        wr(bbas_pkg::bbas_off_configured, 8'h02);
        #1;
        cmp8("configured_port", 8'h02, {6'h0, configured});
    endtask
    task automatic t_ignored(input logic [7:0] ctl_val, input logic [4:0] code);
        wr(bbas_pkg::bbas_off_control, ctl_val);
        sel  <= code;
        fail <= 1'b1;
        repeat (20) @(posedge i_clock);
        #1;
        cmp8("ignored_pin", 8'h02, {6'h0, connect, billboard});
        @(posedge i_clock);
        fail <= 1'b0;
    endtask
    task automatic t_timer_a;
        wr(bbas_pkg::bbas_off_timer_a_lo, 8'h05);
        wr(bbas_pkg::bbas_off_timer_a_hi, 8'h01);
        enter_bb(5'h0a);
        pulse(1'b1, 260 * TICK + 1, 262 * TICK + 3);
    endtask
    task automatic t_timer_b;
        wr(bbas_pkg::bbas_off_timer_b_lo, 8'h03);
        wr(bbas_pkg::bbas_off_timer_b_hi, 8'h00);
        enter_bb(5'h03);
        repeat (5 * TICK) @(posedge i_clock);
        #1;
        cmp8("no_request_stays", 8'h03, {6'h0, connect, billboard});
        pulse(1'b0, 2 * TICK + 1, 4 * TICK + 3);
    endtask

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    initial begin
        {i_rst, reg_wr, reg_rd, fail, addr_cmd, str_cmd} = 6'b100000;
        {reg_addr, reg_wdata, sel} = '0;
        num_errors = 0;
        checks = 0;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        t_regs;
        t_ignored(8'h14, 5'h0a);
        t_ignored(8'h13, 5'h09);
        t_timer_a;
        t_timer_b;
        summarize;
    end
    initial begin
        #100000;
        num_errors++;
        summarize;
    end
    task automatic summarize;
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
endmodule

bind bbas_top bbas_top_monitor #(.TICK_CYCLES(TICK_CYCLES), .DETACH_CYCLES(DETACH_CYCLES)) u_mon (
    .i_clock(i_clock), .i_rst(i_rst), .i_general_pin(i_general_pin), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_connect(o_connect), .o_billboard(o_billboard),
    .o_configured(o_configured));
